// File: common/adcc_pkg.sv
// constants, register map and types of the converter control block
package adcc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam logic [IDX_W-1:0] CHSEL_IDX = 10'h024;
  localparam logic [IDX_W-1:0] MODE_IDX = 10'h025;
  localparam logic [IDX_W-1:0] REF_IDX = 10'h026;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 10'h027;
  localparam logic [IDX_W-1:0] IRQ_CLR_IDX = 10'h028;
  localparam logic [IDX_W-1:0] IRQ_EN_IDX = 10'h029;
  localparam int unsigned MODE_CMP_BIT = 0;
  localparam int unsigned MODE_BUSY_BIT = 1;
  localparam int unsigned MODE_HW_BIT = 2;
  localparam int unsigned CHSEL_W = 3;
  localparam logic [CHSEL_W-1:0] CH_NONE = 3'h0;
  localparam logic [CHSEL_W-1:0] CH_PROHIBIT = 3'h7;
  localparam logic [CHSEL_W-1:0] CHSEL_RST = 3'h0;
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned RES_W = 8;
  localparam logic [RES_W-1:0] REF_RST = 8'h00;
  localparam logic [RES_W-1:0] TRIAL_INIT = 8'h80;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_HW_DONE = 0;
  localparam int unsigned IRQ_SW_CMP = 1;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned INSTR_NS = 2000;
  localparam int unsigned INSTR_CYCLES = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_W = 12;
  localparam int unsigned SW_CMP_INSTR = 3;
  localparam logic [4:0] HW_BUSY_INSTR = 5'h0f;
  localparam logic [4:0] HW_DONE_INSTR = 5'h11;
  localparam logic [4:0] HW_LAST_DECIDE = 5'h0f;
  typedef enum logic {
    SAR_IDLE = 1'b0,
    SAR_RUN = 1'b1
  } adcc_sar_state_type;
endpackage

// File: common/adcc_link_if.sv
// signals between the control top, the approximation sequencer and the pin selector
`timescale 1ns/100ps
`default_nettype none
interface adcc_link_if;
  import adcc_pkg::*;
  logic start;
  logic stop;
  logic cmp_above;
  logic busy;
  logic done;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] result;
  logic [CHSEL_W-1:0] chsel;
  logic [NUM_PINS-1:0] analog_sel;
  logic [NUM_PINS-1:0] force_input;
  modport ctl (output start, stop, cmp_above, input busy, done, trial, result);
  modport sar (input start, stop, cmp_above, output busy, done, trial, result);
  modport pin_ctl (output chsel, input analog_sel, force_input);
  modport pin (input chsel, output analog_sel, force_input);
endinterface
`default_nettype wire

// File: src/adcc_pinsel.sv
// channel decode and forcing of the shared pins into input mode
`timescale 1ns/100ps
`default_nettype none
module adcc_pinsel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // channel and pin modes
  adcc_link_if.pin lnk
);
  import adcc_pkg::*;
  logic [NUM_PINS-1:0] sel_ff;
  logic [NUM_PINS-1:0] force_ff;
  logic any_sel;
  // the prohibited code selects no pin at all
  assign any_sel = (lnk.chsel != CH_NONE) && (lnk.chsel != CH_PROHIBIT); // R7

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sel_ff[i] <= 1'b0;
        force_ff[i] <= 1'b0;
      end else if (pclk_en) begin
        sel_ff[i] <= any_sel && (lnk.chsel == CHSEL_W'(i + 1)); // R7
        force_ff[i] <= any_sel && (lnk.chsel != CHSEL_W'(i + 1)); // R8
      end
    end
  end

  assign lnk.analog_sel = sel_ff;
  assign lnk.force_input = force_ff;

  pin_force_a: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (sel_ff != '0) |-> ($onehot(sel_ff) && (force_ff == ~sel_ff)))
    else $error("unselected pins not forced to input");
  prohibit_code_a: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    (pclk_en && (lnk.chsel == CH_PROHIBIT)) |=> ((sel_ff == '0) && (force_ff == '0)))
    else $error("prohibited channel code drove a pin");
endmodule
`default_nettype wire

// File: src/adcc_sar.sv
// hardware successive approximation sequencer, counted in instruction times
`timescale 1ns/100ps
`default_nettype none
module adcc_sar #(
  parameter int unsigned INSTR_CYC = adcc_pkg::INSTR_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // converter link
  adcc_link_if.sar lnk
);
  import adcc_pkg::*;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(INSTR_CYC - 1);
  if ((INSTR_CYC < 4) || (INSTR_CYC >= (2 ** CYC_W))) begin : g_bad_cyc
    $error("instruction length out of range");
  end

  adcc_sar_state_type state_ff;
  logic [CYC_W-1:0] cyc_ff;
  logic [4:0] instr_ff;
  logic [4:0] nxt_instr;
  logic [RES_W-1:0] trial_ff;
  logic [RES_W-1:0] mask_ff;
  logic [RES_W-1:0] result_ff;
  logic [RES_W-1:0] kept;
  logic busy_ff;
  logic done_ff;
  logic instr_end;
  logic decide;

  assign instr_end = (state_ff == SAR_RUN) && (cyc_ff == CYC_LAST);
  assign nxt_instr = instr_ff + 5'h01;
  // one bit is judged every two instructions, leaving the comparator time to settle
  assign decide = instr_end && instr_ff[0] && (instr_ff <= HW_LAST_DECIDE);
  assign kept = lnk.cmp_above ? trial_ff : (trial_ff & ~mask_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SAR_IDLE;
    end else if (pclk_en) begin
      case (state_ff)
        SAR_IDLE: begin
          if (lnk.start) begin
            state_ff <= SAR_RUN;
          end
        end
        SAR_RUN: begin
          if (lnk.stop || (instr_end && (nxt_instr == HW_DONE_INSTR))) begin
            state_ff <= SAR_IDLE;
          end
        end
        default: state_ff <= SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= '0;
      instr_ff <= '0;
    end else if (pclk_en) begin
      if (lnk.start) begin
        cyc_ff <= '0;
        instr_ff <= '0;
      end else if (instr_end) begin
        cyc_ff <= '0;
        instr_ff <= nxt_instr;
      end else if (state_ff == SAR_RUN) begin
        cyc_ff <= cyc_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_ff <= '0;
      mask_ff <= '0;
    end else if (pclk_en) begin
      if (lnk.start) begin
        trial_ff <= TRIAL_INIT;
        mask_ff <= TRIAL_INIT;
      end else if (lnk.stop) begin
        // a stopped conversion leaves no stale trial value on the ladder
        trial_ff <= '0;
        mask_ff <= '0;
      end else if (decide) begin
        trial_ff <= kept | (mask_ff >> 1); // R5
        mask_ff <= mask_ff >> 1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      result_ff <= '0;
    end else if (pclk_en) begin
      done_ff <= 1'b0;
      if (lnk.start) begin
        busy_ff <= 1'b1; // R6
      end else if (lnk.stop) begin
        busy_ff <= 1'b0; // R12
      end else if (instr_end && (nxt_instr == HW_BUSY_INSTR)) begin
        busy_ff <= 1'b0; // R14
      end else if (instr_end && (nxt_instr == HW_DONE_INSTR)) begin
        done_ff <= 1'b1; // R14
        result_ff <= trial_ff; // R1
      end
    end
  end

  assign lnk.busy = busy_ff;
  assign lnk.done = done_ff;
  assign lnk.trial = trial_ff;
  assign lnk.result = result_ff;

  busy_span_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    ($fell(busy_ff) && !$past(lnk.stop)) |-> (instr_ff == HW_BUSY_INSTR))
    else $error("busy did not clear at instruction fifteen");
  done_time_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    $rose(done_ff) |-> ((instr_ff == HW_DONE_INSTR) && (state_ff == SAR_IDLE)))
    else $error("conversion did not end at instruction seventeen");
  all_bits_a: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    $rose(done_ff) |-> ((mask_ff == '0) && (result_ff == $past(trial_ff))))
    else $error("result loaded before all eight bits were judged");
  hw_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(done_ff));
endmodule
`default_nettype wire

// File: src/adcc_top.sv
// converter channel and mode control with its register slave on the peripheral bus
//
// Behaviour
// R1 - the selected pin is converted to eight bits against an internal reference
// R2 - mode register bit two chooses software single compare or hardware conversion
// R3 - software mode compares pin to software reference, result on mode bit zero
// R4 - software may step the reference bit by bit to approximate the input
// R5 - hardware mode steps the reference itself and yields an eight bit result
// R6 - mode register bit one shows a hardware conversion in progress
// R7 - channel code zero unused, one to six pick pins, seven prohibited
// R8 - a selected pin forces the other five shared pins into input mode
// R9 - software turns off pull-downs of pins zero to three before converting
// R10 - channel register at index 24h, read and write, top bit reads zero
// R11 - channel clears on power-on reset, kept over host enable reset
// R12 - writing one starts hardware conversion, zero stops it; reference write starts compare
// R13 - compare flag is zero when input below reference, one when above
// R14 - conversion ends seventeen instructions after start, busy clears after fifteen
// R15 - software compare result is valid three instructions after the reference write
`timescale 1ns/100ps
`default_nettype none
module adcc_top #(
  parameter int unsigned INSTR_CYC = adcc_pkg::INSTR_CYCLES
) (
  // clock, enable and reset
  input wire logic pclk,
  input wire logic pclk_en,
  input wire logic presetn,
  // peripheral bus slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [adcc_pkg::DATA_W-1:0] pwdata,
  output logic [adcc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // host enable reset, same clock
  input wire logic ce_reset,
  // analog front end
  input wire logic cmp_above_pin,
  output logic [adcc_pkg::RES_W-1:0] ref_level,
  output logic [adcc_pkg::NUM_PINS-1:0] pin_analog_sel,
  output logic [adcc_pkg::NUM_PINS-1:0] pin_force_input,
  // interrupt
  output logic irq
);
  import adcc_pkg::*;
  localparam int unsigned SW_CYC = SW_CMP_INSTR * INSTR_CYC;
  localparam logic [CYC_W-1:0] SW_LAST = CYC_W'(SW_CYC - 1);
  if ((INSTR_CYC < 4) || (SW_CYC >= (2 ** CYC_W))) begin : g_bad_cyc
    $error("instruction length out of range");
  end

  adcc_link_if link ();

  logic [CHSEL_W-1:0] chsel_ff;
  logic hw_mode_ff;
  logic cmp_ff;
  logic [RES_W-1:0] ref_ff;
  logic [RES_W-1:0] ref_out_ff;
  logic [CYC_W-1:0] sw_cnt_ff;
  logic sw_run_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] events;
  logic capt_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] rdata;
  logic cmp_meta_ff;
  logic cmp_sync_ff;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic hit_chsel;
  logic hit_mode;
  logic hit_ref;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic mapped;
  logic wr_acc;
  logic wr_chsel;
  logic wr_mode;
  logic wr_ref;
  logic wr_clr;
  logic wr_en;
  logic sw_done;

  // address decode; word index sits above the byte lanes
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_chsel = aligned && (idx == CHSEL_IDX); // R10
  assign hit_mode = aligned && (idx == MODE_IDX);
  assign hit_ref = aligned && (idx == REF_IDX);
  assign hit_stat = aligned && (idx == IRQ_STAT_IDX);
  assign hit_clr = aligned && (idx == IRQ_CLR_IDX);
  assign hit_en = aligned && (idx == IRQ_EN_IDX);
  assign mapped = hit_chsel | hit_mode | hit_ref | hit_stat | hit_clr | hit_en;

  // a frozen clock stalls the bus instead of dropping a write
  assign pready = psel && penable && capt_ff && pclk_en;
  assign pslverr = pready && !mapped;
  assign wr_acc = pready && pwrite && mapped;
  assign wr_chsel = wr_acc && hit_chsel;
  assign wr_mode = wr_acc && hit_mode;
  assign wr_ref = wr_acc && hit_ref;
  assign wr_clr = wr_acc && hit_clr;
  assign wr_en = wr_acc && hit_en;

  always_comb begin
    rdata = '0;
    if (hit_chsel) begin
      rdata[CHSEL_W-1:0] = chsel_ff; // R10
    end else if (hit_mode) begin
      rdata[MODE_HW_BIT] = hw_mode_ff; // R2
      rdata[MODE_BUSY_BIT] = link.busy; // R6
      rdata[MODE_CMP_BIT] = cmp_ff; // R3
    end else if (hit_ref) begin
      rdata[RES_W-1:0] = ref_ff;
    end else if (hit_stat) begin
      rdata[IRQ_W-1:0] = irq_stat_ff;
    end else if (hit_en) begin
      rdata[IRQ_W-1:0] = irq_en_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (pclk_en) begin
      capt_ff <= psel;
      if (psel) begin
        prdata_ff <= rdata;
      end
    end
  end
  assign prdata = prdata_ff;

  // comparator output comes from the analog domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else if (pclk_en) begin
      cmp_meta_ff <= cmp_above_pin;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // channel select survives the host enable reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chsel_ff <= CHSEL_RST; // R11
    end else if (pclk_en && wr_chsel) begin
      chsel_ff <= pwdata[CHSEL_W-1:0]; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_mode_ff <= 1'b0;
    end else if (pclk_en && wr_mode) begin
      hw_mode_ff <= pwdata[MODE_HW_BIT]; // R2
    end
  end

  assign link.start = wr_mode && pwdata[MODE_HW_BIT]; // R12
  assign link.stop = (wr_mode && !pwdata[MODE_HW_BIT]) || ce_reset; // R12
  assign link.cmp_above = cmp_sync_ff;
  assign link.chsel = chsel_ff;

  // reference register: software owns it in software mode, the sequencer result lands here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ff <= REF_RST;
    end else if (pclk_en) begin
      if (ce_reset && hw_mode_ff) begin
        ref_ff <= REF_RST;
      end else if (link.done) begin
        ref_ff <= link.result; // R5
      end else if (wr_ref && !hw_mode_ff) begin
        ref_ff <= pwdata[RES_W-1:0]; // R4
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_out_ff <= REF_RST;
    end else if (pclk_en) begin
      // busy drops one instruction before the last bit is judged, so follow the mode bit
      ref_out_ff <= hw_mode_ff ? link.trial : ref_ff; // R1
    end
  end
  assign ref_level = ref_out_ff;

  // single compare in software mode; the ladder needs three instructions to settle
  assign sw_done = pclk_en && sw_run_ff && (sw_cnt_ff == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_run_ff <= 1'b0;
      sw_cnt_ff <= '0;
      cmp_ff <= 1'b0;
    end else if (pclk_en) begin
      if (link.start || ce_reset) begin
        sw_run_ff <= 1'b0;
      end else if (wr_ref && !hw_mode_ff) begin
        sw_run_ff <= 1'b1; // R12
        sw_cnt_ff <= SW_LAST; // R15
      end else if (sw_done) begin
        sw_run_ff <= 1'b0;
        cmp_ff <= cmp_sync_ff; // R13
      end else if (sw_run_ff) begin
        sw_cnt_ff <= sw_cnt_ff - 1'b1;
      end
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  assign events[IRQ_HW_DONE] = pclk_en && link.done;
  assign events[IRQ_SW_CMP] = sw_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else if (pclk_en) begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? pwdata[IRQ_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= '0;
    end else if (pclk_en && wr_en) begin
      irq_en_ff <= pwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  adcc_sar #(
    .INSTR_CYC(INSTR_CYC)
  ) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .lnk(link.sar)
  );

  adcc_pinsel u_pinsel (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .lnk(link.pin)
  );

  assign pin_analog_sel = link.analog_sel;
  assign pin_force_input = link.force_input;

  chsel_read_a: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_chsel) |-> (prdata_ff[DATA_W-1:CHSEL_W] == '0))
    else $error("channel register upper bits not zero");
  chsel_keep_a: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (ce_reset && !wr_chsel) |=> $stable(chsel_ff))
    else $error("host enable reset changed the channel");
  start_busy_a: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    (pclk_en && link.start) |=> (link.busy && hw_mode_ff) [*2])
    else $error("busy not raised by hardware start");
  stop_idle_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (pclk_en && wr_mode && !pwdata[MODE_HW_BIT]) |=> (!link.busy && !hw_mode_ff))
    else $error("conversion kept running after stop");
  sw_start_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (pclk_en && wr_ref && !hw_mode_ff && !ce_reset) |=> (sw_run_ff && (sw_cnt_ff == SW_LAST)))
    else $error("reference write did not start a compare");
  sw_result_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    sw_done |=> (cmp_ff == $past(cmp_sync_ff)))
    else $error("compare flag does not follow comparator");
  event_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events != '0) |=> ((irq_stat_ff & $past(events)) == $past(events)))
    else $error("event lost against clear");
  sw_done_c: cover property (@(posedge pclk) disable iff (!presetn) sw_done && cmp_sync_ff);
  chsel_c: cover property (@(posedge pclk) disable iff (!presetn) wr_chsel && (pwdata[2:0] == 3'h6));
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// File: verification/adcc_afe_model.sv
// analog front end model: six pin voltages, reference ladder and comparator
`timescale 1ns/100ps
`default_nettype none
module adcc_afe_model (
  // clock
  input wire logic pclk,
  // converter side
  input wire logic [adcc_pkg::NUM_PINS-1:0] pin_analog_sel,
  input wire logic [adcc_pkg::RES_W-1:0] ref_level,
  // pin voltages, one byte code per pin, pull-downs assumed off
  input wire logic [47:0] pin_volt,
  // comparator
  output logic cmp_above
);
  import adcc_pkg::*;
  logic float_ff = 1'b0;
  // an unselected comparator input floats, so its output is not held steady
  always_ff @(posedge pclk) begin
    float_ff <= ~float_ff;
  end
  // voltage sits half a step above its code, so no input ever equals a tap
  always_comb begin
    cmp_above = float_ff;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_analog_sel[i]) begin
        cmp_above = {pin_volt[i*8+:8], 1'b1} > {ref_level, 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/adcc_top_tb.sv
// self-checking bench for the converter channel and mode control block
`timescale 1ns/100ps
`default_nettype none
module adcc_top_tb;
  import adcc_pkg::*;
  // short instruction time keeps the hardware conversion quick
  localparam int N = 4;
  localparam logic [11:0] A_CH = {CHSEL_IDX, 2'b00};
  localparam logic [11:0] A_MODE = {MODE_IDX, 2'b00};
  localparam logic [11:0] A_REF = {REF_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {IRQ_STAT_IDX, 2'b00};
  localparam logic [11:0] A_CLR = {IRQ_CLR_IDX, 2'b00};
  localparam logic [11:0] A_EN = {IRQ_EN_IDX, 2'b00};
  logic pclk, pclk_en, presetn, psel, penable, pwrite, ce_reset, cmp_above;
  logic pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] ref_level;
  logic [5:0] pin_analog_sel, pin_force_input;
  logic [47:0] pin_volt;
  int errors, checked;

  adcc_top #(.INSTR_CYC(N)) u_adcc_top (.pclk(pclk), .pclk_en(pclk_en), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_reset(ce_reset),
    .cmp_above_pin(cmp_above), .ref_level(ref_level), .pin_analog_sel(pin_analog_sel),
    .pin_force_input(pin_force_input), .irq(irq));
  adcc_afe_model u_adcc_afe_model (.pclk(pclk), .pin_analog_sel(pin_analog_sel),
    .ref_level(ref_level), .pin_volt(pin_volt), .cmp_above(cmp_above));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask

  function automatic logic [5:0] sel_of(input int c);
    return (c >= 1 && c <= 6) ? 6'h01 << (c - 1) : 6'h00;
  endfunction

  task automatic t_reset;
    rd(A_CH, 32'hffffffff, 32'h0);
    rd(A_MODE, 32'hffffffff, 32'h0);
    rd(A_REF, 32'hffffffff, 32'h0);
    rd(A_STAT, 32'hffffffff, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({26'h0, pin_analog_sel | pin_force_input}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_channel;
    for (int c = 0; c < 8; c++) begin
      wr(A_CH, 32'hfffffff8 | 32'(c));
      rd(A_CH, 32'hffffffff, 32'(c));
      @(posedge pclk);
      chk({26'h0, pin_analog_sel}, {26'h0, sel_of(c)});
      chk({26'h0, pin_force_input}, {26'h0, (sel_of(c) != 0) ? ~sel_of(c) : 6'h00});
    end
    $display("channel test done");
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h091, 32'h5, r, e);
    chk({31'h0, e}, 32'h1);
    rd(A_CH, 32'hffffffff, 32'h7);
    $display("unmapped test done");
  endtask

  task automatic t_sw_compare;
    wr(A_CH, 32'h1);
    wr(A_REF, 32'h80);
    rd(A_MODE, 32'hffffffff, 32'h0);
    chk({24'h0, ref_level}, 32'h80);
    repeat (3 * N) @(posedge pclk);
    rd(A_MODE, 32'hffffffff, 32'h1);
    rd(A_STAT, 32'hffffffff, 32'h2);
    wr(A_EN, 32'h2);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_EN, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(A_REF, 32'ha0);
    repeat (3 * N + 2) @(posedge pclk);
    rd(A_MODE, 32'hffffffff, 32'h0);
    wr(A_EN, 32'h2);
    wr(A_CLR, 32'h2);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_STAT, 32'hffffffff, 32'h0);
    $display("software compare test done");
  endtask

  task automatic t_sw_search;
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    v = 8'h00;
    wr(A_CH, 32'h1);
    for (int b = 7; b >= 0; b--) begin
      wr(A_REF, {24'h0, v | (8'h01 << b)});
      repeat (3 * N) @(posedge pclk);
      apb(1'b0, A_MODE, 32'h0, r, e);
      if (r[MODE_CMP_BIT]) v = v | (8'h01 << b);
    end
    chk({24'h0, v}, 32'h90);
    $display("software search test done");
  endtask

  task automatic t_clock_enable;
    wr(A_REF, 32'h80);
    pclk_en <= 1'b0;
    repeat (4 * N) @(posedge pclk);
    pclk_en <= 1'b1;
    rd(A_MODE, 32'h1, 32'h0);
    repeat (3 * N) @(posedge pclk);
    rd(A_MODE, 32'h1, 32'h1);
    $display("clock enable test done");
  endtask

  task automatic t_hw_convert;
    wr(A_CH, 32'h4);
    wr(A_EN, 32'h1);
    wr(A_MODE, 32'h4);
    rd(A_MODE, 32'h6, 32'h6);
    repeat (15 * N - 6) @(posedge pclk);
    rd(A_MODE, 32'h6, 32'h6);
    repeat (2) @(posedge pclk);
    rd(A_MODE, 32'h6, 32'h4);
    repeat (2 * N + 2) @(posedge pclk);
    rd(A_REF, 32'hff, 32'ha5);
    rd(A_STAT, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(A_CLR, 32'h1);
    wr(A_EN, 32'h0);
    wr(A_CH, 32'h6);
    wr(A_MODE, 32'h4);
    repeat (17 * N + 2) @(posedge pclk);
    rd(A_REF, 32'hff, 32'hb4);
    wr(A_CLR, 32'h1);
    $display("hardware conversion test done");
  endtask

  task automatic t_hw_stop;
    wr(A_MODE, 32'h4);
    repeat (5 * N) @(posedge pclk);
    wr(A_MODE, 32'h0);
    rd(A_MODE, 32'h6, 32'h0);
    repeat (17 * N) @(posedge pclk);
    rd(A_STAT, 32'h1, 32'h0);
    $display("hardware stop test done");
  endtask

  task automatic t_resets;
    wr(A_CH, 32'h3);
    ce_reset <= 1'b1;
    @(posedge pclk);
    ce_reset <= 1'b0;
    rd(A_CH, 32'hffffffff, 32'h3);
    chk({26'h0, pin_analog_sel}, 32'h4);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CH, 32'hffffffff, 32'h0);
    chk({26'h0, pin_analog_sel | pin_force_input}, 32'h0);
    $display("reset retention test done");
  endtask

  initial begin
    errors = 0;
    checked = 0;
    pclk_en = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ce_reset = 1'b0;
    pin_volt = 48'hb400_a500_0090;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_channel;
    t_unmapped;
    t_sw_compare;
    t_sw_search;
    t_clock_enable;
    t_hw_convert;
    t_hw_stop;
    t_resets;
    complete_run;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
